// *** logic/pasb_pkg.sv ***
// Constants for the protection and alarm status bank.
// Assumes a 16-bit word-addressed read port and 16-bit data words.
package pasb_pkg;

   // ----------------------------------------------------------------
   // Word layout
   // ----------------------------------------------------------------
   localparam int          PASB_DW        = 16;    // Data word width
   localparam int          PASB_AW        = 16;    // Word address width
   localparam int          PASB_INV_BIT   = 15;    // Word-invalid flag
   localparam int          PASB_NWORDS    = 5;     // Status/quality pairs

   // ----------------------------------------------------------------
   // Word addresses (status word sits just above its quality word)
   // ----------------------------------------------------------------
   localparam logic [15:0] STD_OVR_QUAL_ADDR  = 16'h7d0d;
   localparam logic [15:0] STD_OVR_STAT_ADDR  = 16'h7d0e;
   localparam logic [15:0] ADV_OVR_QUAL_ADDR  = 16'h7d0f;
   localparam logic [15:0] ADV_OVR_STAT_ADDR  = 16'h7d10;
   localparam logic [15:0] EXT_OVR_QUAL_ADDR  = 16'h7d11;
   localparam logic [15:0] EXT_OVR_STAT_ADDR  = 16'h7d12;
   localparam logic [15:0] PREALM_QUAL_ADDR   = 16'h7d13;
   localparam logic [15:0] PREALM_STAT_ADDR   = 16'h7d14;
   localparam logic [15:0] USRALM_QUAL_ADDR   = 16'h7d15;
   localparam logic [15:0] USRALM_STAT_ADDR   = 16'h7d16;
   localparam logic [15:0] BANK_FIRST_ADDR    = STD_OVR_QUAL_ADDR;

   // ----------------------------------------------------------------
   // Number of defined bits per status word (bits from 0 upward)
   // ----------------------------------------------------------------
   localparam int          STD_OVR_NBITS  = 1;     // Long-time pickup
   localparam int          ADV_OVR_NBITS  = 15;    // Bits 0..14
   localparam int          EXT_OVR_NBITS  = 2;     // Ground, leakage
   localparam int          PREALM_NBITS   = 3;     // Three pre-alarms
   localparam int          USRALM_NBITS   = 8;     // Alarms 201..208

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int          STD_LONG_TIME_PICKUP_BIT = 0;
   localparam int          ADV_CUR_UNBAL_BIT        = 0;
   localparam int          ADV_MAX_I1_BIT           = 1;
   localparam int          ADV_MAX_I2_BIT           = 2;
   localparam int          ADV_MAX_I3_BIT           = 3;
   localparam int          ADV_MAX_IN_BIT           = 4;
   localparam int          ADV_MIN_VOLT_BIT         = 5;
   localparam int          ADV_MAX_VOLT_BIT         = 6;
   localparam int          ADV_VOLT_UNBAL_BIT       = 7;
   localparam int          ADV_MAX_POWER_BIT        = 8;
   localparam int          ADV_REV_POWER_BIT        = 9;
   localparam int          ADV_MIN_FREQ_BIT         = 10;
   localparam int          ADV_MAX_FREQ_BIT         = 11;
   localparam int          ADV_PHASE_ROT_BIT        = 12;
   localparam int          ADV_SHED_CURRENT_BIT     = 13;
   localparam int          ADV_SHED_POWER_BIT       = 14;
   localparam int          EXT_GROUND_FAULT_BIT     = 0;
   localparam int          EXT_EARTH_LEAK_BIT       = 1;
   localparam int          long_time_prealarm_bit     = 0;
   localparam int          earth_leakage_prealarm_bit = 1;
   localparam int          ground_fault_prealarm_bit  = 2;
   localparam int          USR_ALARM_FIRST_BIT      = 0;   // Alarm 201

   // ----------------------------------------------------------------
   // Values after reset
   // ----------------------------------------------------------------
   localparam logic [15:0] STAT_RST_VAL   = 16'h8000;  // Word invalid
   localparam logic [15:0] QUAL_RST_VAL   = 16'h0000;  // Nothing valid
   localparam logic [15:0] RD_DATA_RST    = 16'h0000;

   // Synchroniser depth on the indication inputs
   localparam int          SYNC_STAGES    = 2;

endpackage

// *** logic/pasb_sync.sv ***
// Two flip-flop level synchroniser for a vector of indications.
// Assumes each bit is an independent slow level from another domain.
`timescale 1ns/1ps
module pasb_sync
   import pasb_pkg::*;
#(
   parameter int W = 1                        // Vector width
)
(
   input  wire logic         core_clk_in,     // Core clock
   input  wire logic         rst_n_in,        // Async reset, active low
   input  wire logic [W-1:0] async_in,        // Raw level inputs
   output logic      [W-1:0] sync_out         // Synchronised levels
);

   // ----------------------------------------------------------------
   // Stages
   // ----------------------------------------------------------------
   logic [W-1:0] meta_r;                      // First stage, read only
   logic [W-1:0] sync_r;                      // Second stage
   logic [W-1:0] meta_nxt;
   logic [W-1:0] sync_nxt;

   // Next values: the first stage feeds only the second stage
   always_comb
   begin
      meta_nxt = async_in;
      sync_nxt = meta_r;
   end

   // Registers
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_r <= '0;
         sync_r <= '0;
      end
      else
      begin
         meta_r <= meta_nxt;
         sync_r <= sync_nxt;
      end
   end

   assign sync_out = sync_r;

endmodule

// *** logic/pasb_bank.sv ***
// Protection setpoint overrun and alarm status bank, read-only.
// Assumes indications arrive as levels from the protection logic in
// another domain, and a word-addressed read/write port from the
// fieldbus slave on core_clk_in.
`timescale 1ns/1ps
module pasb_bank
   import pasb_pkg::*;
(
   input  wire logic                      core_clk_in,      // 200 MHz
   input  wire logic                      rst_n_in,         // Async
   // Indications, levels, from another domain
   input  wire logic [STD_OVR_NBITS-1:0]  std_overrun_in,   // Pickups
   input  wire logic [ADV_OVR_NBITS-1:0]  adv_overrun_in,   // Pickups
   input  wire logic [EXT_OVR_NBITS-1:0]  ext_overrun_in,   // Alarms
   input  wire logic [PREALM_NBITS-1:0]   prealarm_in,      // Active
   input  wire logic [USRALM_NBITS-1:0]   user_alarm_in,    // Active
   // Per-bit validity, same layout as the indications
   input  wire logic [STD_OVR_NBITS-1:0]  std_valid_in,
   input  wire logic [ADV_OVR_NBITS-1:0]  adv_valid_in,
   input  wire logic [EXT_OVR_NBITS-1:0]  ext_valid_in,
   input  wire logic [PREALM_NBITS-1:0]   prealarm_valid_in,
   input  wire logic [USRALM_NBITS-1:0]   user_valid_in,
   // Whole-word invalid, one per status word, std first in bit 0
   input  wire logic [PASB_NWORDS-1:0]    word_invalid_in,
   // Register port
   input  wire logic                      rd_en_in,         // Read
   input  wire logic                      wr_en_in,         // Write
   input  wire logic [PASB_AW-1:0]        addr_in,          // Word addr
   output logic      [PASB_DW-1:0]        rd_data_out,      // Data
   output logic                           rd_valid_out,     // Pulse
   output logic                           rd_hit_out,       // Mapped
   output logic                           wr_ignored_out    // Pulse
);

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   localparam int NIND = STD_OVR_NBITS + ADV_OVR_NBITS + EXT_OVR_NBITS
                       + PREALM_NBITS + USRALM_NBITS;
   localparam int NALL = 2 * NIND + PASB_NWORDS;

   logic [NALL-1:0] raw_all;                  // Packed raw inputs
   logic [NALL-1:0] syn_all;                  // Packed synced inputs
   logic [NIND-1:0] syn_ind;                  // Synced indications
   logic [NIND-1:0] syn_val;                  // Synced validity
   logic [PASB_NWORDS-1:0] syn_inv;           // Synced word invalid

   assign raw_all = {word_invalid_in,
                     user_valid_in, prealarm_valid_in, ext_valid_in,
                     adv_valid_in, std_valid_in,
                     user_alarm_in, prealarm_in, ext_overrun_in,
                     adv_overrun_in, std_overrun_in};

   // One synchroniser for every raw level
   pasb_sync #(.W(NALL)) u_sync
   (
      .core_clk_in (core_clk_in),
      .rst_n_in    (rst_n_in),
      .async_in    (raw_all),
      .sync_out    (syn_all)
   );

   assign syn_ind = syn_all[NIND-1:0];
   assign syn_val = syn_all[2*NIND-1:NIND];
   assign syn_inv = syn_all[NALL-1:2*NIND];

   // ----------------------------------------------------------------
   // Word builders
   // ----------------------------------------------------------------
   // Places n defined bits at the bottom, zeroes the rest up to 14
   function automatic logic [14:0] low_field(input logic [14:0] v,
                                             input int         n);
      logic [14:0] m;
      m = 15'(({15'h0, 15'h7fff} >> (15 - n)));
      return v & m;
   endfunction

   // Offsets of each word's bits inside the packed indication vector
   localparam int STD_LSB = 0;
   localparam int ADV_LSB = STD_LSB + STD_OVR_NBITS;
   localparam int EXT_LSB = ADV_LSB + ADV_OVR_NBITS;
   localparam int PRE_LSB = EXT_LSB + EXT_OVR_NBITS;
   localparam int USR_LSB = PRE_LSB + PREALM_NBITS;

   logic [14:0] ind_fld [PASB_NWORDS];        // Defined status bits
   logic [14:0] val_fld [PASB_NWORDS];        // Defined validity bits

   // Each word takes its slice; the slice lengths fix field positions
   // standard word bit 0
   always_comb
   begin
      ind_fld[0] = low_field(15'(syn_ind >> STD_LSB), STD_OVR_NBITS);
      ind_fld[1] = low_field(15'(syn_ind >> ADV_LSB), ADV_OVR_NBITS);
      ind_fld[2] = low_field(15'(syn_ind >> EXT_LSB), EXT_OVR_NBITS);
      ind_fld[3] = low_field(15'(syn_ind >> PRE_LSB), PREALM_NBITS);
      ind_fld[4] = low_field(15'(syn_ind >> USR_LSB), USRALM_NBITS);
      val_fld[0] = low_field(15'(syn_val >> STD_LSB), STD_OVR_NBITS);
      val_fld[1] = low_field(15'(syn_val >> ADV_LSB), ADV_OVR_NBITS);
      val_fld[2] = low_field(15'(syn_val >> EXT_LSB), EXT_OVR_NBITS);
      val_fld[3] = low_field(15'(syn_val >> PRE_LSB), PREALM_NBITS);
      val_fld[4] = low_field(15'(syn_val >> USR_LSB), USRALM_NBITS);
   end

   // ----------------------------------------------------------------
   // Status and quality word registers
   // ----------------------------------------------------------------
   logic [PASB_DW-1:0] stat_r   [PASB_NWORDS];  // Status words
   logic [PASB_DW-1:0] qual_r   [PASB_NWORDS];  // Quality words
   logic [PASB_DW-1:0] stat_nxt [PASB_NWORDS];
   logic [PASB_DW-1:0] qual_nxt [PASB_NWORDS];

   genvar g;
   generate
      for (g = 0; g < PASB_NWORDS; g++)
      begin : g_word
         // Words follow the live levels every cycle: an overrun shows
         // at pickup and an alarm holds exactly as long as it is on
         always_comb
         begin
            stat_nxt[g][14:0] = ind_fld[g];
            // bit 15 flags whole word invalid
            stat_nxt[g][PASB_INV_BIT] = syn_inv[g];
            // quality bit n validates status bit n
            qual_nxt[g][14:0] = val_fld[g];
            // Flag bit itself always carries valid information
            qual_nxt[g][PASB_INV_BIT] = 1'b1;
         end

         // Registers
         always_ff @(posedge core_clk_in or negedge rst_n_in)
         begin
            if (!rst_n_in)
            begin
               stat_r[g] <= STAT_RST_VAL;
               qual_r[g] <= QUAL_RST_VAL;
            end
            else
            begin
               stat_r[g] <= stat_nxt[g];
               qual_r[g] <= qual_nxt[g];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // Read and write port
   // ----------------------------------------------------------------
   logic [PASB_DW-1:0] rd_data_r;             // Read data
   logic               rd_valid_r;            // Read answer strobe
   logic               rd_hit_r;              // Address was mapped
   logic               wr_ign_r;              // Write was dropped
   logic [PASB_DW-1:0] rd_data_nxt;
   logic               rd_valid_nxt;
   logic               rd_hit_nxt;
   logic               wr_ign_nxt;
   logic [PASB_AW-1:0] rel_addr;              // Offset into the bank

   assign rel_addr = addr_in - BANK_FIRST_ADDR;

   // Decode: a read captures the addressed word; the word index is
   // the offset halved, the low offset bit picks status over quality
   always_comb
   begin
      rd_data_nxt  = rd_data_r;
      rd_valid_nxt = 1'b0;
      rd_hit_nxt   = rd_hit_r;
      wr_ign_nxt   = wr_en_in & ~rd_en_in;
      if (rd_en_in)
      begin
         rd_valid_nxt = 1'b1;
         rd_hit_nxt   = 1'b0;
         rd_data_nxt  = RD_DATA_RST;
         if (rel_addr < 16'(2 * PASB_NWORDS))
         begin
            rd_hit_nxt = 1'b1;
            // status at quality address plus one
            if (rel_addr[0])
               rd_data_nxt = stat_r[rel_addr[3:1]];
            else
               rd_data_nxt = qual_r[rel_addr[3:1]];
         end
      end
   end

   // Registers; a read wins if read and write come together
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rd_data_r  <= RD_DATA_RST;
         rd_valid_r <= 1'b0;
         rd_hit_r   <= 1'b0;
         wr_ign_r   <= 1'b0;
      end
      else
      begin
         rd_data_r  <= rd_data_nxt;
         rd_valid_r <= rd_valid_nxt;
         rd_hit_r   <= rd_hit_nxt;
         wr_ign_r   <= wr_ign_nxt;
      end
   end

   assign rd_data_out    = rd_data_r;
   assign rd_valid_out   = rd_valid_r;
   assign rd_hit_out     = rd_hit_r;
   assign wr_ignored_out = wr_ign_r;

endmodule

// *** verif/pasb_bank_properties.sv ***
// Checker for the read port of the status bank.
// Assumes it is bound to every pasb_bank instance, one clock.
`timescale 1ns/1ps
module pasb_bank_properties
   import pasb_pkg::*;
(
   input  wire logic               core_clk_in,
   input  wire logic               rst_n_in,
   input  wire logic               rd_en_in,
   input  wire logic               wr_en_in,
   input  wire logic [PASB_AW-1:0] addr_in,
   input  wire logic [PASB_DW-1:0] rd_data_out,
   input  wire logic               rd_valid_out,
   input  wire logic               rd_hit_out,
   input  wire logic               wr_ignored_out
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   logic mapped;                           // Address inside the bank
   assign mapped = (addr_in >= BANK_FIRST_ADDR) &&
                   (addr_in <= USRALM_STAT_ADDR);
   // Bits that must read 0; unmapped reads must be all 0
   function automatic logic [15:0] rsvd(input logic [15:0] a);
      case (a)
         STD_OVR_QUAL_ADDR, STD_OVR_STAT_ADDR: rsvd = 16'h7ffe;
         ADV_OVR_QUAL_ADDR, ADV_OVR_STAT_ADDR: rsvd = 16'h0000;
         EXT_OVR_QUAL_ADDR, EXT_OVR_STAT_ADDR: rsvd = 16'h7ffc;
         PREALM_QUAL_ADDR, PREALM_STAT_ADDR:   rsvd = 16'h7ff8;
         USRALM_QUAL_ADDR, USRALM_STAT_ADDR:   rsvd = 16'h7f00;
         default:                              rsvd = 16'hffff;
      endcase
   endfunction
   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   a_rd_answer: assert property (rd_en_in |=> rd_valid_out &&
      (rd_hit_out == $past(mapped))) else $error("read answer wrong");
   a_idle_hold: assert property (!rd_en_in |=> !rd_valid_out &&
      $stable(rd_data_out) && $stable(rd_hit_out))
      else $error("outputs moved without a read");
   a_rsvd_zero: assert property (rd_en_in |=>
      (rd_data_out & rsvd($past(addr_in))) == 16'h0000)
      else $error("reserved bit set");
   // Quality words sit at odd addresses; their flag bit reads 1
   a_qual_flag: assert property (rd_en_in && mapped && addr_in[0]
      |=> rd_data_out[PASB_INV_BIT]) else $error("quality bit 15 low");
   a_wr_pulse: assert property (wr_en_in && !rd_en_in
      |=> wr_ignored_out) else $error("dropped write not flagged");
   a_wr_quiet: assert property (!(wr_en_in && !rd_en_in)
      |=> !wr_ignored_out) else $error("spurious write flag");
   a_unmap_zero: assert property (rd_en_in && !mapped
      |=> rd_data_out == 16'h0000 && !rd_hit_out)
      else $error("unmapped read not zero");
   a_rdwr_read: assert property (rd_en_in && wr_en_in
      |=> rd_valid_out && !wr_ignored_out) else $error("read+write");
   c_mapped: cover property (rd_en_in && mapped);
   c_unmapped: cover property (rd_en_in && !mapped);
   c_write: cover property (wr_en_in && !rd_en_in);
endmodule
bind pasb_bank pasb_bank_properties u_props (.core_clk_in, .rst_n_in,
   .rd_en_in, .wr_en_in, .addr_in, .rd_data_out, .rd_valid_out,
   .rd_hit_out, .wr_ignored_out);

// *** verif/pasb_master.sv ***
// Behavioural fieldbus master that polls the status bank.
// Assumes the bench calls xfer from one process only.
`timescale 1ns/1ps
module pasb_master
   import pasb_pkg::*;
(
   input  wire logic               core_clk_in,
   input  wire logic [PASB_DW-1:0] rd_data_in,
   input  wire logic               rd_valid_in,
   input  wire logic               rd_hit_in,
   input  wire logic               wr_ignored_in,
   output logic                    rd_en_out,
   output logic                    wr_en_out,
   output logic      [PASB_AW-1:0] addr_out
);
   // ------------------------------------------------------------
   // One strobe, then the answer sampled just after the edge that takes it
   // ------------------------------------------------------------
   initial
   begin
      rd_en_out = 1'b0;
      wr_en_out = 1'b0;
      addr_out  = 16'h0000;
   end
   task automatic xfer(input logic r, input logic w,
      input logic [15:0] a, output logic [15:0] d, output logic v,
      output logic h, output logic i);
      @(posedge core_clk_in);
      rd_en_out <= r;
      wr_en_out <= w;
      addr_out  <= a;
      @(posedge core_clk_in);
      rd_en_out <= 1'b0;
      wr_en_out <= 1'b0;
      // Released address shows a changing pattern, not the old one
      addr_out  <= ~a;
      #1;
      d = rd_data_in;
      v = rd_valid_in;
      h = rd_hit_in;
      i = wr_ignored_in;
   endtask
endmodule

// *** verif/pasb_bank_tb.sv ***
// Self-checking bench for the status bank.
// Assumes pasb_master and the bound checker are compiled first.
`timescale 1ns/1ps
module pasb_bank_tb
   import pasb_pkg::*;
;
   logic        core_clk_in, rst_n_in;   // Clock and reset
   logic        std_ov, std_v;           // Standard pickup
   logic [14:0] adv_ov, adv_v;           // Advanced pickups
   logic [1:0]  ext_ov, ext_v;           // Extended alarms
   logic [2:0]  pre_al, pre_v;           // Pre-alarms
   logic [7:0]  usr_al, usr_v;           // User alarms
   logic [4:0]  wi;                      // Word invalid flags
   logic        rd_en, wr_en, v, h, i, rv, hit, ign;
   logic [15:0] addr, rdat, d, a;
   logic [31:0] r1, r2, r3;
   int          n_fail, checks, cyc;
   pasb_bank dut (.core_clk_in, .rst_n_in, .std_overrun_in(std_ov),
      .adv_overrun_in(adv_ov), .ext_overrun_in(ext_ov),
      .prealarm_in(pre_al), .user_alarm_in(usr_al),
      .std_valid_in(std_v), .adv_valid_in(adv_v), .ext_valid_in(ext_v),
      .prealarm_valid_in(pre_v), .user_valid_in(usr_v),
      .word_invalid_in(wi), .rd_en_in(rd_en), .wr_en_in(wr_en),
      .addr_in(addr), .rd_data_out(rdat), .rd_valid_out(rv),
      .rd_hit_out(hit), .wr_ignored_out(ign));
   pasb_master m (.core_clk_in, .rd_data_in(rdat), .rd_valid_in(rv),
      .rd_hit_in(hit), .wr_ignored_in(ign), .rd_en_out(rd_en),
      .wr_en_out(wr_en), .addr_out(addr));
   // ------------------------------------------------------------
   // Reference model and compares
   // ------------------------------------------------------------
   function automatic logic [15:0] expw(input logic [15:0] x);
      case (x)
         STD_OVR_QUAL_ADDR: expw = {1'b1, 14'h0, std_v};
         STD_OVR_STAT_ADDR: expw = {wi[0], 14'h0, std_ov};
         ADV_OVR_QUAL_ADDR: expw = {1'b1, adv_v};
         ADV_OVR_STAT_ADDR: expw = {wi[1], adv_ov};
         EXT_OVR_QUAL_ADDR: expw = {1'b1, 13'h0, ext_v};
         EXT_OVR_STAT_ADDR: expw = {wi[2], 13'h0, ext_ov};
         PREALM_QUAL_ADDR:  expw = {1'b1, 12'h0, pre_v};
         PREALM_STAT_ADDR:  expw = {wi[3], 12'h0, pre_al};
         USRALM_QUAL_ADDR:  expw = {1'b1, 7'h0, usr_v};
         USRALM_STAT_ADDR:  expw = {wi[4], 7'h0, usr_al};
         default:           expw = 16'h0000;
      endcase
   endfunction
   task automatic chk_w(input logic [15:0] g, input logic [15:0] e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic chk_b(input logic g, input logic e);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   // Read one word and compare data, answer and hit
   task automatic rdchk(input logic [15:0] x);
      m.xfer(1'b1, 1'b0, x, d, v, h, i);
      chk_w(d, expw(x));
      chk_b(v, 1'b1);
      chk_b(h, x >= BANK_FIRST_ADDR && x <= USRALM_STAT_ADDR);
   endtask
   task automatic conclude();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Clock and hang guard
   // ------------------------------------------------------------
   always #2.5 core_clk_in = ~core_clk_in;
   always @(posedge core_clk_in)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_fail++;
         conclude();
      end
   end
   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial
   begin
      {core_clk_in, rst_n_in, std_ov, std_v, adv_ov, adv_v} = '0;
      {ext_ov, ext_v, pre_al, pre_v, usr_al, usr_v, wi} = '0;
      {n_fail, checks, cyc} = '0;
      r1 = $urandom(32'hfc06);
      repeat (3) @(posedge core_clk_in);
      rst_n_in <= 1'b1;
      repeat (4) @(posedge core_clk_in);
      // Random levels held while every word is polled
      repeat (24)
      begin
         r1 = $urandom;
         r2 = $urandom;
         r3 = $urandom;
         @(posedge core_clk_in);
         {usr_al, pre_al, ext_ov, adv_ov, std_ov} <= r1[28:0];
         {pre_v, ext_v, adv_v, std_v, wi} <= r2[25:0];
         usr_v <= r3[7:0];
         // Let the new levels pass both synchroniser stages and the word registers
         repeat (4) @(posedge core_clk_in);
         // quality word polled before its status word
         for (a = STD_OVR_QUAL_ADDR; a <= USRALM_STAT_ADDR; a++)
            rdchk(a);
      end
      $display("test random polling done");
      // Holes on either side of the bank and the top of the space
      for (int k = 0; k < 4; k++)
         rdchk(k[0] ? 16'h7d0c : (k[1] ? 16'h7d17 : 16'hffff));
      $display("test unmapped done");
      for (a = STD_OVR_QUAL_ADDR; a <= USRALM_STAT_ADDR; a++)
      begin
         // Lone write: flagged as dropped, no read answer
         m.xfer(1'b0, 1'b1, a, d, v, h, i);
         chk_b(i, 1'b1);
         chk_b(v, 1'b0);
         // Read with write: the read wins and the word is untouched
         m.xfer(1'b1, 1'b1, a, d, v, h, i);
         chk_b(i, 1'b0);
         chk_w(d, expw(a));
      end
      $display("test writes done");
      conclude();
   end
endmodule
